/* hw/ipav_pkg.sv */
// Constants for the interrupt priority and autovector controller.
// Assumes a single 200 MHz clock and an Avalon-MM register master.
// Behaviour
// - Within a level, internal codes 11 and 10 outrank the external slot.
// - Pin 7 is a fixed level 7 external slot, between codes 10 and 01.
// - Pin-assign bit 1 set puts pin 3 at level 6, else level 3.
// - Pin-assign bit 2 set puts pin 5 at level 4, else level 5.
// - Pin-assign bit 0 set puts pin 1 at level 2, else level 1.
// - Simultaneous requests at one level are served strictly in ranked order.
// - Autovector bits 7..1 choose autovector per external level.
// - Autovector bit 0 keeps address strobe off in external autovectored acknowledge.
// - Autovector offset is 0x64 plus four times level minus one.
// - An external autovector bit counts only while that level is assigned.
// - Internal sources take autovector choice from their own control entry.
// - Seven levels of five ranked positions give thirty-five slots.
// - Internal priority code 00 is lowest, 11 highest.
// - Mask blocks request to core; pending still records it.
package ipav_pkg;
  localparam int NUM_INT = 10;         // Internal sources
  localparam int NUM_LVL = 7;          // Interrupt levels
  localparam int NUM_SRC = 17;         // Pending bits 17..1
  // Register byte offsets
  localparam logic [7:0] OFS_PEND   = 8'h40;
  localparam logic [7:0] OFS_MASK   = 8'h44;
  localparam logic [7:0] OFS_AVSEL  = 8'h48;
  localparam logic [7:0] OFS_CTRL0  = 8'h4C; // Four entries per word
  localparam logic [7:0] OFS_CTRL1  = 8'h50;
  localparam logic [7:0] OFS_CTRL2  = 8'h54;
  localparam logic [7:0] OFS_PINAS  = 8'h58;
  localparam logic [7:0] OFS_ACKVEC = 8'h5C;
  // Reset values
  localparam logic [17:1] MASK_RST  = 17'h1FFFF;
  localparam logic [7:0]  AVSEL_RST = 8'h00;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [2:0]  PINAS_RST = 3'h0;
  // Control entry fields
  localparam int CTRL_AV  = 7;
  localparam int CTRL_LVH = 4;
  localparam int CTRL_LVL = 2;
  // Vector offsets
  localparam logic [7:0] AV_BASE = 8'h64;
  localparam logic [7:0] NO_VEC  = 8'h00;
  // Pin-assign field positions in the pin-assign register
  localparam int PIN_LSB = 5;
  // Acknowledge sequencer states
  typedef enum logic [2:0] {
    IPAV_IDLE = 3'b001,
    IPAV_ACK  = 3'b010,
    IPAV_DONE = 3'b100
  } ipav_state_t;
endpackage

/* hw/ipav_resolve.sv */
// Ranks pending unmasked requests over the 35 slots; internal entries at level 0 are skipped.
// Assumes control entries are unique per level and priority.
`timescale 1ns/1ps
module ipav_resolve (
  input  wire logic [79:0] ctrl_in,   // Ten control entries
  input  wire logic [9:0]  int_req_in, // Unmasked internal requests
  input  wire logic [7:1]  ext_lvl_in, // Unmasked external per level
  output logic      [2:0]  lvl_out,   // Winning level, 0 if none
  output logic             ext_out,   // Winner is the external slot
  output logic      [3:0]  src_out    // Winning internal index
);
  // Slot rank = level*5 + position; linear scan keeps highest
  always_comb begin
    logic [5:0] best;
    logic [5:0] r;
    logic [2:0] lv;
    logic [1:0] pr;
    best    = 6'h00;
    r       = 6'h00;
    lv      = 3'h0;
    pr      = 2'h0;
    lvl_out = 3'h0;
    ext_out = 1'b0;
    src_out = 4'h0;
    for (int l = 1; l <= 7; l++) begin
      r = 6'(l * 5 + 2); // External sits between 10 and 01
      if (ext_lvl_in[l] && r > best) begin
        best    = r;
        lvl_out = 3'(l);
        ext_out = 1'b1;
      end
    end
    for (int i = 0; i < 10; i++) begin
      lv = ctrl_in[i*8+ipav_pkg::CTRL_LVL +: 3];
      pr = ctrl_in[i*8 +: 2];
      // Codes 11,10 above slot; 01,00 below
      // Widen before adding: a two-bit sum would wrap code 11 to the bottom
      r = 6'(lv * 5) + 6'(pr) + (pr[1] ? 6'h01 : 6'h00);
      if (int_req_in[i] && lv != 3'h0 && r > best) begin
        best    = r;
        lvl_out = lv;
        ext_out = 1'b0;
        src_out = 4'(i);
      end
    end
  end
endmodule // ipav_resolve

/* hw/ipav_top.sv */
// Interrupt priority and autovector controller with Avalon-MM slave.
// Assumes request inputs are synchronous active-high levels.
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module ipav_top (
  input  wire logic        CLK_SYS_IN,      // 200 MHz clock
  input  wire logic        SRST_IN,         // Sync reset, high
  input  wire logic [7:0]  AVM_ADDRESS_IN,  // Byte address
  input  wire logic        AVM_READ_IN,     // Read request
  input  wire logic        AVM_WRITE_IN,    // Write request
  input  wire logic [31:0] AVM_WRITEDATA_IN, // Write data
  input  wire logic [3:0]  AVM_BYTEENABLE_IN, // Byte lanes
  output logic      [31:0] AVM_READDATA_OUT, // Read data
  output logic             AVM_WAITREQUEST_OUT, // Stall
  input  wire logic [9:0]  INT_REQ_IN,      // Internal requests
  input  wire logic        EXT_REQUEST_PIN_7_IN, // Pin 7
  input  wire logic        EXT_REQUEST_PIN_5_IN, // Pin 5
  input  wire logic        EXT_REQUEST_PIN_3_IN, // Pin 3
  input  wire logic        EXT_REQUEST_PIN_1_IN, // Pin 1
  input  wire logic        IACK_IN,         // Core acknowledge pulse
  input  wire logic [2:0]  IACK_LEVEL_IN,   // Level acknowledged
  output logic      [2:0]  IRQ_LEVEL_OUT,   // Level to core
  output logic             IACK_DONE_OUT,   // Acknowledge answered
  output logic             IACK_AUTO_OUT,   // Autovector supplied
  output logic      [7:0]  IACK_VEC_OUT,    // Autovector offset
  output logic             ADDR_STROBE_BLOCK_OUT, // Strobe off
  output logic             IRQ_OUT          // Unmasked pending
);
  ipav_pkg::ipav_state_t st_q, st_d;
  logic [17:1] mask_q, pend_q;
  logic [7:0]  avsel_q;
  logic [7:0]  ctrl_q [10];
  logic [2:0]  pinas_q;
  logic [31:0] rdata_q;
  logic        wait_q;
  logic [2:0]  lvl_q;
  logic        done_q, auto_q, blk_q;
  logic [7:0]  vec_q;
  logic [2:0]  ack_lvl_q;
  logic [79:0] ctrl_flat;
  logic [7:1]  ext_pend, ext_unm;
  logic [2:0]  win_lvl;
  logic        win_ext;
  logic [3:0]  win_src;
  logic        irq_q;
  logic [7:1]  lvl_en;
  logic [7:0]  mask_b0, mask_b2, pin_byte;

  // Vector offset for level n: 0x64 + 4*(n-1)
  function automatic logic [7:0] av_offset(input logic [2:0] n);
    av_offset = ipav_pkg::AV_BASE + {3'h0, n - 3'h1, 2'h0};
  endfunction

  // Byte-lane merge for writes
  function automatic logic [7:0] lane(input logic [7:0] old,
                                      input int b);
    lane = AVM_BYTEENABLE_IN[b] ? AVM_WRITEDATA_IN[b*8 +: 8] : old;
  endfunction

  // Pins mapped to levels by pin-assign bits
  assign ext_pend[7] = EXT_REQUEST_PIN_7_IN;
  assign ext_pend[6] = EXT_REQUEST_PIN_3_IN & pinas_q[1];
  assign ext_pend[3] = EXT_REQUEST_PIN_3_IN & ~pinas_q[1];
  assign ext_pend[4] = EXT_REQUEST_PIN_5_IN & pinas_q[2];
  assign ext_pend[5] = EXT_REQUEST_PIN_5_IN & ~pinas_q[2];
  assign ext_pend[2] = EXT_REQUEST_PIN_1_IN & pinas_q[0];
  assign ext_pend[1] = EXT_REQUEST_PIN_1_IN & ~pinas_q[0];

  // Pending bits follow sources every clock; mask only gates them
  assign ext_unm = pend_q[7:1] & ~mask_q[7:1];
  generate
    for (genvar g = 0; g < 10; g++) begin : g_flat
      assign ctrl_flat[g*8 +: 8] = ctrl_q[g];
    end
  endgenerate

  ipav_resolve u_resolve (
    .ctrl_in    (ctrl_flat),
    .int_req_in (pend_q[17:8] & ~mask_q[17:8]),
    .ext_lvl_in (ext_unm),
    .lvl_out    (win_lvl),
    .ext_out    (win_ext),
    .src_out    (win_src)
  );

  // Levels live under a pin-assign setting; pin 7 is always live and
  // each other pin owns exactly one of its two levels
  function automatic logic [7:1] lvl_map(input logic [2:0] pa);
    lvl_map = {1'b1, pa[1], ~pa[2], pa[2], ~pa[1], pa[0], ~pa[0]};
  endfunction

  assign lvl_en = lvl_map(pinas_q);

  // Autovector choice for the winning request; a level bit is ignored
  // unless the pin assignment has that level live
  wire win_auto = win_ext ? (avsel_q[win_lvl] & lvl_en[win_lvl])
                          : ctrl_q[win_src][ipav_pkg::CTRL_AV];

  // Register decode
  wire acc      = AVM_READ_IN | AVM_WRITE_IN;
  wire go       = acc & ~wait_q;   // Answer cycle, waitrequest low
  wire wr       = AVM_WRITE_IN & go;
  wire a_mask   = AVM_ADDRESS_IN == ipav_pkg::OFS_MASK;
  wire a_pend   = AVM_ADDRESS_IN == ipav_pkg::OFS_PEND;
  wire a_avsel  = AVM_ADDRESS_IN == ipav_pkg::OFS_AVSEL;
  wire a_c0     = AVM_ADDRESS_IN == ipav_pkg::OFS_CTRL0;
  wire a_c1     = AVM_ADDRESS_IN == ipav_pkg::OFS_CTRL1;
  wire a_c2     = AVM_ADDRESS_IN == ipav_pkg::OFS_CTRL2;
  wire a_pinas  = AVM_ADDRESS_IN == ipav_pkg::OFS_PINAS;
  wire a_ackv   = AVM_ADDRESS_IN == ipav_pkg::OFS_ACKVEC;
  wire [31:0] rd_mux =
      a_pend  ? {14'h0, pend_q, 1'b0} :
      a_mask  ? {14'h0, mask_q, 1'b0} :
      a_avsel ? {24'h0, avsel_q} :
      a_c0    ? {ctrl_q[0], ctrl_q[1], ctrl_q[2], ctrl_q[3]} :
      a_c1    ? {ctrl_q[4], ctrl_q[5], ctrl_q[6], ctrl_q[7]} :
      a_c2    ? {ctrl_q[8], ctrl_q[9], 16'h0} :
      a_pinas ? {24'h0, pinas_q, 5'h0} :
      a_ackv  ? {21'h0, lvl_q, vec_q} : 32'h0;

  // Merged bytes for the narrow registers, cut to width where used
  assign mask_b0  = lane({mask_q[7:1], 1'b0}, 0);
  assign mask_b2  = lane({6'h00, mask_q[17:16]}, 2);
  assign pin_byte = lane({pinas_q, 5'h00}, 0);

  // Bus handshake: one wait cycle, then answer
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q  <= ~(acc & wait_q);
      if (AVM_READ_IN & wait_q) rdata_q <= rd_mux;
    end
  end

  // Writable registers; pending is read-only and samples each clock
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      mask_q  <= ipav_pkg::MASK_RST;
      avsel_q <= ipav_pkg::AVSEL_RST;
      pinas_q <= ipav_pkg::PINAS_RST;
      pend_q  <= 17'h0;
      for (int i = 0; i < 10; i++) ctrl_q[i] <= ipav_pkg::CTRL_RST;
    end else begin
      pend_q <= {INT_REQ_IN, ext_pend};
      if (wr & a_mask) begin
        mask_q[7:1]   <= mask_b0[7:1];
        mask_q[15:8]  <= lane(mask_q[15:8], 1);
        mask_q[17:16] <= mask_b2[1:0];
      end
      if (wr & a_avsel) avsel_q <= lane(avsel_q, 0);
      if (wr & a_pinas) pinas_q <= pin_byte[ipav_pkg::PIN_LSB +: 3];
      // Duplicate level/priority entries are software's error
      for (int b = 0; b < 4; b++) begin
        if (wr & a_c0) ctrl_q[3-b]   <= lane(ctrl_q[3-b], b) & 8'h9F;
        if (wr & a_c1) ctrl_q[7-b]   <= lane(ctrl_q[7-b], b) & 8'h9F;
      end
      for (int b = 2; b < 4; b++)
        if (wr & a_c2) ctrl_q[11-b] <= lane(ctrl_q[11-b], b) & 8'h9F;
    end
  end

  // Acknowledge sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ipav_pkg::IPAV_IDLE: if (IACK_IN) st_d = ipav_pkg::IPAV_ACK;
      ipav_pkg::IPAV_ACK:  st_d = ipav_pkg::IPAV_DONE;
      ipav_pkg::IPAV_DONE: st_d = ipav_pkg::IPAV_IDLE;
      default:             st_d = ipav_pkg::IPAV_IDLE;
    endcase
  end

  // Level to core and acknowledge answer
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      st_q      <= ipav_pkg::IPAV_IDLE;
      lvl_q     <= 3'h0;
      irq_q     <= 1'b0;
      done_q    <= 1'b0;
      auto_q    <= 1'b0;
      vec_q     <= ipav_pkg::NO_VEC;
      blk_q     <= 1'b0;
      ack_lvl_q <= 3'h0;
    end else begin
      st_q   <= st_d;
      irq_q  <= win_lvl != 3'h0; // Own flop keeps the pin glitch free
      lvl_q  <= win_lvl;
      done_q <= st_q == ipav_pkg::IPAV_ACK;
      if (st_q == ipav_pkg::IPAV_IDLE && IACK_IN) ack_lvl_q <= IACK_LEVEL_IN;
      if (st_q == ipav_pkg::IPAV_ACK) begin
        // Answer for the request now ranked top overall, if it sits at the acked level
        auto_q <= win_auto && win_lvl == ack_lvl_q;
        vec_q  <= (win_auto && win_lvl == ack_lvl_q)
                  ? av_offset(ack_lvl_q) : ipav_pkg::NO_VEC;
        blk_q  <= win_auto && win_ext && win_lvl == ack_lvl_q
                  && avsel_q[0];
      end else if (st_q == ipav_pkg::IPAV_DONE) begin
        blk_q  <= 1'b0;
      end
    end
  end

  assign AVM_READDATA_OUT      = rdata_q;
  assign AVM_WAITREQUEST_OUT   = wait_q;
  assign IRQ_LEVEL_OUT         = lvl_q;
  assign IRQ_OUT               = irq_q;
  assign IACK_DONE_OUT         = done_q;
  assign IACK_AUTO_OUT         = auto_q;
  assign IACK_VEC_OUT          = vec_q;
  assign ADDR_STROBE_BLOCK_OUT = blk_q;
endmodule // ipav_top

/* dv/ipav_props.sv */
// Port checker for the priority and autovector controller.
// Assumes binding onto ipav_top; one clock, synchronous reset.
`timescale 1ns/1ps
module ipav_props (
  input wire logic       CLK_SYS_IN,
  input wire logic       SRST_IN,
  input wire logic       AVM_READ_IN,
  input wire logic       AVM_WRITE_IN,
  input wire logic       AVM_WAITREQUEST_OUT,
  input wire logic       IACK_IN,
  input wire logic [2:0] IACK_LEVEL_IN,
  input wire logic [2:0] IRQ_LEVEL_OUT,
  input wire logic       IACK_DONE_OUT,
  input wire logic       IACK_AUTO_OUT,
  input wire logic [7:0] IACK_VEC_OUT,
  input wire logic       ADDR_STROBE_BLOCK_OUT,
  input wire logic       IRQ_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SRST_IN);
  // Bus answers exactly one cycle after a request, for one cycle
  a_wait_answer: assert property ((AVM_READ_IN || AVM_WRITE_IN) &&
    AVM_WAITREQUEST_OUT |=> !AVM_WAITREQUEST_OUT) else $error("no answer");
  a_wait_single: assert property (!AVM_WAITREQUEST_OUT |=>
    AVM_WAITREQUEST_OUT) else $error("waitrequest low too long");
  // Flag mirrors the presented level
  a_irq_flag: assert property (IRQ_OUT == (IRQ_LEVEL_OUT != 3'h0))
    else $error("irq flag wrong");
  // Acknowledge answered two cycles on, as a single pulse
  a_ack_answer: assert property (IACK_IN |-> ##2 IACK_DONE_OUT)
    else $error("ack not answered");
  a_done_pulse: assert property (IACK_DONE_OUT |=> !IACK_DONE_OUT)
    else $error("done too long");
  // Offset is tied to the level taken two cycles before
  a_vec_offset: assert property (IACK_DONE_OUT && IACK_AUTO_OUT |->
    IACK_VEC_OUT == 8'h60 + {3'h0, $past(IACK_LEVEL_IN, 2), 2'h0})
    else $error("bad vector offset");
  a_vec_hold: assert property (
    !IACK_DONE_OUT |-> $stable(IACK_VEC_OUT))
    else $error("vector moved between acks");
  // Strobe is only blocked for an autovectored answer, then released
  a_block_auto: assert property (
    ADDR_STROBE_BLOCK_OUT |-> IACK_AUTO_OUT)
    else $error("strobe blocked without autovector");
  a_block_clear: assert property (IACK_DONE_OUT |=>
    !ADDR_STROBE_BLOCK_OUT) else $error("strobe block stuck");
  c_auto: cover property (IACK_DONE_OUT && IACK_AUTO_OUT);
  c_source: cover property (IACK_DONE_OUT && !IACK_AUTO_OUT);
  c_block: cover property (ADDR_STROBE_BLOCK_OUT);
endmodule // ipav_props

/* dv/ipav_core_model.sv */
// Core-side model: runs acknowledge cycles for the presented level.
// Assumes the controller's acknowledge outputs are wired back in.
`timescale 1ns/1ps
module ipav_core_model (
  input  wire logic       clk_in,       // System clock
  input  wire logic [2:0] level_in,     // Presented level
  input  wire logic       done_in,      // Acknowledge answered
  input  wire logic       auto_in,      // Autovector flag
  input  wire logic [7:0] vec_in,       // Vector offset
  input  wire logic       blk_in,       // Strobe blocked
  output logic            iack_out,     // Acknowledge pulse
  output logic      [2:0] iack_lvl_out  // Level acknowledged
);
  initial begin
    iack_out = 1'b0;
    iack_lvl_out = 3'h0;
  end
  // Level held until answered; two idle edges keep the minimum spacing
  task automatic acknowledge(output logic ok, output logic a,
                             output logic [7:0] v, output logic b);
    int n;
    n = 0;
    @(posedge clk_in);
    iack_out <= 1'b1;
    iack_lvl_out <= level_in;
    @(posedge clk_in);
    iack_out <= 1'b0;
    do begin @(posedge clk_in); n++; end while (done_in !== 1'b1 && n < 20);
    ok = done_in; // Low here means the answer never came
    a = auto_in;
    v = vec_in;
    b = blk_in;
    repeat (2) @(posedge clk_in);
  endtask
endmodule // ipav_core_model

/* dv/interrupt_priority_autovector_bench.sv */
// Self-checking bench for the priority and autovector controller.
// Assumes ipav_top, ipav_core_model and ipav_props compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module interrupt_priority_autovector_bench;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic p7 = 1'b0, p5 = 1'b0, p3 = 1'b0, p1 = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [9:0] ireq = 10'h000;
  logic iack, wrq, done, auto, strobe_suppress, irq, a_q, b_q, ok_q;
  logic [2:0] ilv, lvl;
  logic [7:0] vec, v_q;
  int err_count = 0, checks_done = 0, cyc = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  ipav_top DUT (.CLK_SYS_IN(clk), .SRST_IN(rst), .AVM_ADDRESS_IN(adr),
    .AVM_READ_IN(rd), .AVM_WRITE_IN(wr), .AVM_WRITEDATA_IN(wd),
    .AVM_BYTEENABLE_IN(4'hF), .AVM_READDATA_OUT(rdat),
    .AVM_WAITREQUEST_OUT(wrq), .INT_REQ_IN(ireq),
    .EXT_REQUEST_PIN_7_IN(p7), .EXT_REQUEST_PIN_5_IN(p5),
    .EXT_REQUEST_PIN_3_IN(p3), .EXT_REQUEST_PIN_1_IN(p1),
    .IACK_IN(iack), .IACK_LEVEL_IN(ilv), .IRQ_LEVEL_OUT(lvl),
    .IACK_DONE_OUT(done), .IACK_AUTO_OUT(auto), .IACK_VEC_OUT(vec),
    .ADDR_STROBE_BLOCK_OUT(strobe_suppress), .IRQ_OUT(irq));
  ipav_core_model core (.clk_in(clk), .level_in(lvl), .done_in(done),
    .auto_in(auto), .vec_in(vec), .blk_in(strobe_suppress), .iack_out(iack),
    .iack_lvl_out(ilv));
  // One access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a; wd <= d; wr <= w; rd <= !w;
    do begin @(posedge clk); n++; end while (wrq !== 1'b0 && n < 20);
    q = rdat;
    if (wrq !== 1'b0) err_count++; // A bus hang counts as a mismatch
    wr <= 1'b0; rd <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  // Level has a fixed two-cycle latency, so a fixed wait is safe
  task automatic lv(input logic [2:0] e);
    repeat (3) @(posedge clk);
    `CHK(lvl, e)
    `CHK(irq, e != 3'h0)
  endtask
  // Vector is checked either way: no autovector means a zero offset
  task automatic ack(input logic ea, input logic [7:0] ev);
    core.acknowledge(ok_q, a_q, v_q, b_q);
    `CHK(ok_q, 1'b1)
    `CHK(a_q, ea)
    `CHK(v_q, ev)
  endtask
  // Reset values, read-only pending, unmapped place
  task automatic t_map();
    chk_rd(8'h44, 32'h0003FFFE);
    chk_rd(8'h48, 32'h00000000);
    bus(1'b1, 8'h40, 32'h0003FFFE);
    chk_rd(8'h40, 32'h00000000);
    chk_rd(8'h7C, 32'h00000000);
  endtask
  // Codes 10 and 01 around the external slot at level 6, unique entries
  task automatic t_rank();
    bus(1'b1, 8'h50, 32'h791A0000);
    chk_rd(8'h50, 32'h191A0000);
    bus(1'b1, 8'h58, 32'h00000040);
    bus(1'b1, 8'h48, 32'h00000041);
    bus(1'b1, 8'h44, 32'h00000000);
    ireq <= 10'h030;
    p3 <= 1'b1;
    lv(3'h6);
    chk_rd(8'h40, 32'h00003040);
    ack(1'b0, 8'h00);
    ireq <= 10'h010;
    lv(3'h6);
    ack(1'b1, 8'h78);
    `CHK(b_q, 1'b1)
    p3 <= 1'b0;
    lv(3'h6);
    ack(1'b0, 8'h00);
    ireq <= 10'h000;
  endtask
  // Pin 3 back at level 3; level 6 bit must not apply
  task automatic t_pin();
    bus(1'b1, 8'h58, 32'h00000000);
    p3 <= 1'b1;
    lv(3'h3);
    ack(1'b0, 8'h00);
    bus(1'b1, 8'h48, 32'h00000008);
    ack(1'b1, 8'h6C);
    `CHK(b_q, 1'b0)
    p3 <= 1'b0;
  endtask
  // Pins 1, 5 and 7 under both assignments
  task automatic t_table();
    logic [2:0] el [6] = '{3'h1, 3'h5, 3'h7, 3'h2, 3'h4, 3'h7};
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 8'h58, i < 3 ? 32'h0 : 32'hE0);
      {p1, p5, p7} <= 3'b100 >> (i % 3);
      lv(el[i]);
      {p1, p5, p7} <= 3'b000;
    end
  endtask
  // Masked request stays pending but never reaches the core
  task automatic t_mask();
    bus(1'b1, 8'h58, 32'h00000000);
    bus(1'b1, 8'h44, 32'h00000002);
    p1 <= 1'b1;
    lv(3'h0);
    chk_rd(8'h40, 32'h00000002);
    bus(1'b1, 8'h44, 32'h00000000);
    lv(3'h1);
    p1 <= 1'b0;
  endtask
  // Level 7: code 11 above pin 7, pin 7 above code 00; internal entries
  // take autovector from their own entry and never block the strobe
  task automatic t_top();
    bus(1'b1, 8'h48, 32'h00000001);
    bus(1'b1, 8'h50, 32'h191A9F9C);
    ireq <= 10'h0C0;
    p7 <= 1'b1;
    lv(3'h7);
    ack(1'b1, 8'h7C);
    `CHK(b_q, 1'b0)
    ireq <= 10'h080;
    lv(3'h7);
    ack(1'b0, 8'h00);
    `CHK(b_q, 1'b0)
    p7 <= 1'b0;
    lv(3'h7);
    ack(1'b1, 8'h7C);
    ireq <= 10'h000;
  endtask
  task automatic conclude();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_map();
    t_rank();
    t_pin();
    t_table();
    t_mask();
    t_top();
    conclude();
  end
endmodule // interrupt_priority_autovector_bench
bind ipav_top ipav_props u_props (
  .CLK_SYS_IN            (CLK_SYS_IN),
  .SRST_IN               (SRST_IN),
  .AVM_READ_IN           (AVM_READ_IN),
  .AVM_WRITE_IN          (AVM_WRITE_IN),
  .AVM_WAITREQUEST_OUT   (AVM_WAITREQUEST_OUT),
  .IACK_IN               (IACK_IN),
  .IACK_LEVEL_IN         (IACK_LEVEL_IN),
  .IRQ_LEVEL_OUT         (IRQ_LEVEL_OUT),
  .IACK_DONE_OUT         (IACK_DONE_OUT),
  .IACK_AUTO_OUT         (IACK_AUTO_OUT),
  .IACK_VEC_OUT          (IACK_VEC_OUT),
  .ADDR_STROBE_BLOCK_OUT (ADDR_STROBE_BLOCK_OUT),
  .IRQ_OUT               (IRQ_OUT)
);
